// ===== ssr_pkg.sv
package ssr_pkg;
	localparam logic [7:0] READ_SECURITY_STATUS_CMD  = 8'h2B;
	localparam logic [7:0] WRITE_SECURITY_STATUS_CMD = 8'h2F;
	localparam logic [7:0] SET_WRITE_LATCH_CMD       = 8'h06;
	localparam logic [7:0] CLEAR_WRITE_LATCH_CMD     = 8'h04;
	localparam logic [7:0] ENTER_SECURE_AREA_CMD     = 8'hB1;
	localparam logic [7:0] LEAVE_SECURE_AREA_CMD     = 8'hC1;
	localparam logic [7:0] DEEP_SLEEP_CMD            = 8'hB9;
	localparam logic [7:0] WAKE_CMD                  = 8'hAB;
	localparam int         FACTORY_LOCK_BIT          = 0;
	localparam int         LOCKDOWN_BIT              = 1;
	localparam int         CONT_PROG_BIT             = 4;
	localparam logic [2:0] BIT_COUNT_LAST            = 3'h7;
	localparam logic       CONT_PROG_RESET           = 1'b0;
	typedef enum logic [1:0] {
		SSR_IDLE,
		SSR_CMD,
		SSR_READ,
		SSR_IGNORE
	} ssr_state_e;
endpackage

// ===== ssr_security_status.sv
`timescale 1ns/1ns
module ssr_security_status
	import ssr_pkg::*;
(
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic cs_n,
	input  wire logic sclk,
	input  wire logic si,
	output logic      so,
	output logic      so_oe,
	input  wire logic factory_locked,
	input  wire logic busy,
	input  wire logic continuous_program_mode,
	output logic      customer_lockdown_bit,
	output logic      write_latch_flag,
	output logic      secure_area_mode,
	output logic      main_array_blocked,
	output logic      secure_area_write_ok,
	output logic      deep_sleep
);
	logic [1:0] cs_sync;
	logic [1:0] ck_sync;
	logic [1:0] si_sync;
	logic       ck_prev;
	logic       cs_prev;
	ssr_state_e state;
	logic [2:0] bit_cnt;
	logic [7:0] shift_in;
	logic [7:0] shift_out;
	logic [7:0] last_cmd;
	logic       byte_done;
	logic       factory_q;

	wire cs_low    = ~cs_sync[1];
	wire rise      = ck_sync[1] & ~ck_prev;
	wire fall      = ~ck_sync[1] & ck_prev;
	wire cs_fall   = cs_low & ~cs_prev;
	wire cs_rise   = ~cs_low & cs_prev;
	wire [7:0] next_shift_in = {shift_in[6:0], si_sync[1]};
	wire last_bit  = rise & (bit_cnt == BIT_COUNT_LAST);
	wire [7:0] status_word = {3'h0, continuous_program_mode, 2'h0,
		customer_lockdown_bit, factory_q};
	// write only when deselect lands on a whole byte
	wire on_boundary = byte_done & (bit_cnt == 3'h0);
	// write latch not consulted; refused in secure area
	wire do_write = cs_rise & on_boundary & ~deep_sleep & ~busy
		& (last_cmd == WRITE_SECURITY_STATUS_CMD) & ~secure_area_mode;
	wire cmd_end  = cs_rise & on_boundary;

	// main array closed while secure area mapped in
	assign main_array_blocked   = secure_area_mode;
	// secure area writable only before lockdown
	assign secure_area_write_ok = secure_area_mode & ~customer_lockdown_bit;

	// link pins are asynchronous, two-stage sync before use
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cs_sync <= 2'h3;
			ck_sync <= 2'h0;
			si_sync <= 2'h0;
			ck_prev <= 1'b0;
			cs_prev <= 1'b0;
		end else begin
			cs_sync <= {cs_sync[0], cs_n};
			ck_sync <= {ck_sync[0], sclk};
			si_sync <= {si_sync[0], si};
			ck_prev <= ck_sync[1];
			cs_prev <= cs_low;
		end
	end

	// strap sampled every clock after reset release, never under reset
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			factory_q <= 1'b0;
		else
			factory_q <= factory_locked;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state     <= SSR_IDLE;
			bit_cnt   <= 3'h0;
			shift_in  <= 8'h00;
			shift_out <= 8'h00;
			last_cmd  <= 8'h00;
			byte_done <= 1'b0;
		end else if (!cs_low) begin
			state     <= SSR_IDLE;
			bit_cnt   <= 3'h0;
			byte_done <= 1'b0;
		end else begin
			if (cs_fall) begin
				state     <= SSR_CMD;
				bit_cnt   <= 3'h0;
				byte_done <= 1'b0;
				last_cmd  <= 8'h00;
			end else if (rise) begin
				bit_cnt  <= bit_cnt + 3'h1;
				shift_in <= next_shift_in;
				if (last_bit)
					byte_done <= 1'b1;
				unique case (state)
					SSR_CMD: begin
						if (last_bit) begin
							last_cmd <= next_shift_in;
							if (next_shift_in == READ_SECURITY_STATUS_CMD
								&& !deep_sleep)
								state <= SSR_READ;
							else
								state <= SSR_IGNORE;
						end
					end
					SSR_READ: ;
					SSR_IGNORE: begin
						if (last_bit)
							last_cmd <= 8'h00;
					end
					SSR_IDLE: ;
				endcase
			end
			// reload status each byte, repeats until deselect
			if (fall && state == SSR_READ) begin
				if (bit_cnt == 3'h0)
					shift_out <= status_word;
				else
					shift_out <= {shift_out[6:0], 1'b0};
			end
		end
	end

	assign so    = shift_out[7];
	assign so_oe = cs_low & (state == SSR_READ);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			deep_sleep            <= 1'b0;
			// write latch cleared by power-on reset
			write_latch_flag      <= 1'b0;
			customer_lockdown_bit <= 1'b0;
			secure_area_mode      <= 1'b0;
		end else if (cmd_end && !busy) begin
			if (deep_sleep) begin
				if (last_cmd == WAKE_CMD)
					deep_sleep <= 1'b0;
			end else begin
				if (last_cmd == DEEP_SLEEP_CMD)
					deep_sleep <= 1'b1;
				if (last_cmd == SET_WRITE_LATCH_CMD)
					write_latch_flag <= 1'b1;
				if (last_cmd == CLEAR_WRITE_LATCH_CMD)
					write_latch_flag <= 1'b0;
				if (last_cmd == ENTER_SECURE_AREA_CMD)
					secure_area_mode <= 1'b1;
				if (last_cmd == LEAVE_SECURE_AREA_CMD)
					secure_area_mode <= 1'b0;
				if (do_write)
					customer_lockdown_bit <= 1'b1;
			end
		end
	end

	a_lock_sticky: assert property (@(posedge mclk) disable iff (rst)
		$past(customer_lockdown_bit) |-> customer_lockdown_bit)
		else $error("lockdown bit cleared");
	// lockdown rises only from a valid write
	a_lock_cause: assert property (@(posedge mclk) disable iff (rst)
		$rose(customer_lockdown_bit) |-> $past(do_write))
		else $error("lockdown set without write");
	// no write while secure area mapped
	a_write_secure: assert property (@(posedge mclk) disable iff (rst)
		secure_area_mode && !customer_lockdown_bit
		|=> !customer_lockdown_bit)
		else $error("write taken in secure area");
	a_write_bound: assert property (@(posedge mclk) disable iff (rst)
		do_write |-> byte_done && bit_cnt == 3'h0)
		else $error("write off byte boundary");
	// array blocked exactly in secure mode
	a_array_block: assert property (@(posedge mclk) disable iff (rst)
		main_array_blocked == secure_area_mode)
		else $error("array access while secure");
	a_resv_zero: assert property (@(posedge mclk) disable iff (rst)
		(status_word & 8'hEC) == 8'h00)
		else $error("reserved bit set");
	// output enabled only while selected in read
	a_read_drive: assert property (@(posedge mclk) disable iff (rst)
		so_oe |-> cs_low && state == SSR_READ)
		else $error("output driven while deselected");
	a_read_busy: assert property (@(posedge mclk) disable iff (rst)
		state == SSR_CMD && last_bit && !deep_sleep
		&& next_shift_in == READ_SECURITY_STATUS_CMD |=> state == SSR_READ)
		else $error("read refused");
	// bit 4 follows continuous program mode
	a_cp_bit: assert property (@(posedge mclk) disable iff (rst)
		status_word[CONT_PROG_BIT] == continuous_program_mode)
		else $error("cp bit mismatch");

	a_oe_deselect: assert property (@(posedge mclk) disable iff (rst)
		!cs_low |-> !so_oe)
		else $error("output enabled while deselected");

	a_idle_deselect: assert property (@(posedge mclk) disable iff (rst)
		!cs_low |=> state == SSR_IDLE)
		else $error("frame not ended on deselect");

	a_oe_idle: assert property (@(posedge mclk) disable iff (rst)
		state == SSR_IDLE |-> !so_oe)
		else $error("output enabled in idle");

	a_status_load: assert property (@(posedge mclk) disable iff (rst)
		cs_low && fall && state == SSR_READ && bit_cnt == 3'h0
		|=> shift_out == $past(status_word))
		else $error("status byte not loaded");

	// read refused only in deep sleep
	a_read_sleep: assert property (@(posedge mclk) disable iff (rst)
		state == SSR_CMD && last_bit && deep_sleep |=> state != SSR_READ)
		else $error("read taken in deep sleep");

	a_write_nolatch: assert property (@(posedge mclk) disable iff (rst)
		do_write |=> customer_lockdown_bit)
		else $error("valid write not applied");

	a_write_busy: assert property (@(posedge mclk) disable iff (rst)
		busy |=> customer_lockdown_bit == $past(customer_lockdown_bit))
		else $error("write taken while busy");

	a_write_sleep: assert property (@(posedge mclk) disable iff (rst)
		deep_sleep && !customer_lockdown_bit |=> !customer_lockdown_bit)
		else $error("write taken in deep sleep");

	a_unaligned: assert property (@(posedge mclk) disable iff (rst)
		cs_rise && !on_boundary |=> $stable(customer_lockdown_bit))
		else $error("unaligned write applied");

	a_factory_bit: assert property (@(posedge mclk) disable iff (rst)
		status_word[FACTORY_LOCK_BIT] == factory_q)
		else $error("factory bit mismatch");

	a_lock_bit: assert property (@(posedge mclk) disable iff (rst)
		status_word[LOCKDOWN_BIT] == customer_lockdown_bit)
		else $error("lockdown bit mismatch");

	a_otp_frozen: assert property (@(posedge mclk) disable iff (rst)
		customer_lockdown_bit |-> !secure_area_write_ok)
		else $error("secure area writable after lockdown");

	a_enter_secure: assert property (@(posedge mclk) disable iff (rst)
		$rose(secure_area_mode)
		|-> $past(cmd_end && last_cmd == ENTER_SECURE_AREA_CMD))
		else $error("secure mode without enter");

	a_leave_secure: assert property (@(posedge mclk) disable iff (rst)
		$fell(secure_area_mode)
		|-> $past(cmd_end && last_cmd == LEAVE_SECURE_AREA_CMD))
		else $error("secure mode left without command");

	// latch set only by its command
	a_latch_rise: assert property (@(posedge mclk) disable iff (rst)
		$rose(write_latch_flag)
		|-> $past(cmd_end && last_cmd == SET_WRITE_LATCH_CMD))
		else $error("latch set without command");

	a_sleep_rise: assert property (@(posedge mclk) disable iff (rst)
		$rose(deep_sleep) |-> $past(cmd_end && last_cmd == DEEP_SLEEP_CMD))
		else $error("sleep entered without command");
endmodule

// ===== ssr_host_model.sv
`timescale 1ns/1ns
module ssr_host_model (
	input  wire logic mclk,
	input  wire logic so,
	output logic      cs_n,
	output logic      sclk,
	output logic      si
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		si   = 1'b0;
	end
	task automatic gap(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask
	task automatic frame(logic [23:0] tx, int n, output logic [23:0] rx);
		rx = 24'h000000;
		gap(4);
		cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			si = tx[i];
			gap(4);
			sclk = 1'b1;
			gap(4);
			rx[i] = so;
			sclk = 1'b0;
		end
		// released line: no stale level
		si = ~si;
		gap(2);
		cs_n = 1'b1;
		gap(8);
	endtask
endmodule

// ===== testbench.sv
`timescale 1ns/1ns
module testbench
	import ssr_pkg::*;
;
	logic        mclk, rst, factory_locked, busy, continuous_program_mode;
	logic        cs_n, sclk, si, so, so_oe, customer_lockdown_bit;
	logic        write_latch_flag, secure_area_mode, main_array_blocked;
	logic        secure_area_write_ok, deep_sleep;
	logic [23:0] rx;
	logic [10:0] rows [4] = '{11'h000, 11'h401, 11'h310, 11'h711};
	int          failures = 0;
	int          check_count = 0;
	ssr_security_status ssr_security_status_inst (.*);
	ssr_host_model      ssr_host_model_inst (.*);
	always #10 mclk = ~mclk;
	task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic cmd(logic [23:0] tx, int n);
		ssr_host_model_inst.frame(tx, n, rx);
	endtask
	// whole run is about 2000 clocks
	initial begin
		#200000;
		failures++;
		report_and_stop();
	end
	initial begin
		{mclk, rst, factory_locked, busy, continuous_program_mode} = 5'h08;
		repeat (4) @(posedge mclk);
		#2 rst = 1'b0;
		foreach (rows[i]) begin
			{factory_locked, continuous_program_mode, busy} = rows[i][10:8];
			cmd({READ_SECURITY_STATUS_CMD, 16'h0000}, 24);
			check("status", rx[15:8], rows[i][7:0]);
			check("repeat", rx[7:0], rows[i][7:0]);
		end
		{factory_locked, continuous_program_mode, busy} = 3'h0;
		$display("rows done");
		cmd({16'h0000, SET_WRITE_LATCH_CMD}, 8);
		check("latch", {7'h00, write_latch_flag}, 8'h01);
		rst = 1'b1;
		#40 rst = 1'b0;
		check("latch", {7'h00, write_latch_flag}, 8'h00);
		check("sleep", {7'h00, deep_sleep}, 8'h00);
		check("oe", {7'h00, so_oe}, 8'h00);
		$display("reset test done");
		cmd({15'h0000, WRITE_SECURITY_STATUS_CMD, 1'b0}, 9);
		check("lock", {7'h00, customer_lockdown_bit}, 8'h00);
		cmd({16'h0000, ENTER_SECURE_AREA_CMD}, 8);
		check("blocked", {7'h00, main_array_blocked}, 8'h01);
		check("otp_ok", {7'h00, secure_area_write_ok}, 8'h01);
		cmd({16'h0000, WRITE_SECURITY_STATUS_CMD}, 8);
		check("lock", {7'h00, customer_lockdown_bit}, 8'h00);
		cmd({16'h0000, LEAVE_SECURE_AREA_CMD}, 8);
		check("blocked", {7'h00, main_array_blocked}, 8'h00);
		cmd({16'h0000, WRITE_SECURITY_STATUS_CMD}, 8);
		check("lock", {7'h00, customer_lockdown_bit}, 8'h01);
		cmd({READ_SECURITY_STATUS_CMD, 16'h0000}, 24);
		check("status", rx[15:8], 8'h02);
		cmd({16'h0000, ENTER_SECURE_AREA_CMD}, 8);
		check("otp_ok", {7'h00, secure_area_write_ok}, 8'h00);
		cmd({16'h0000, WRITE_SECURITY_STATUS_CMD}, 8);
		check("lock", {7'h00, customer_lockdown_bit}, 8'h01);
		$display("lock test done");
		cmd({16'h0000, SET_WRITE_LATCH_CMD}, 8);
		check("latch", {7'h00, write_latch_flag}, 8'h01);
		cmd({16'h0000, CLEAR_WRITE_LATCH_CMD}, 8);
		check("latch", {7'h00, write_latch_flag}, 8'h00);
		cmd({16'h0000, DEEP_SLEEP_CMD}, 8);
		check("sleep", {7'h00, deep_sleep}, 8'h01);
		cmd({16'h0000, SET_WRITE_LATCH_CMD}, 8);
		check("latch", {7'h00, write_latch_flag}, 8'h00);
		cmd({16'h0000, WAKE_CMD}, 8);
		check("sleep", {7'h00, deep_sleep}, 8'h00);
		$display("sleep test done");
		report_and_stop();
	end
endmodule
